// ### bis_pkg.sv
// Shared constants and types for the boot integrity supervisor
package bis_pkg;
   localparam int CLK_HZ          = 40_000_000;
   localparam int WDT_TIMEOUT_US  = 1000;
   localparam int WDT_CYCLES      = WDT_TIMEOUT_US * (CLK_HZ / 1_000_000);
   localparam int FA_W            = 12;
   localparam int DATA_W          = 32;
   localparam int CHK_W           = 6;
   localparam int FAST_PWM_OUTPUTS_W          = 8;
   localparam int STRAP_W         = 7;
   localparam int IR_W            = 4;
   localparam int NPARAM          = 4;
   localparam logic [11:0] FW_BASE  = 12'h000;
   localparam logic [11:0] FW_LAST  = 12'h0FF;
   localparam logic [11:0] CFG_BASE = 12'h100;
   localparam logic [11:0] CFG_LAST = 12'h03F;
   localparam logic [11:0] LOG_BASE = 12'h140;
   localparam logic [11:0] LOG_LAST = 12'h03F;
   localparam logic [6:0]  ADDR_MIN = 7'h08;
   localparam logic [6:0]  ADDR_MAX = 7'h77;
   localparam logic [31:0] BLANK_WORD = 32'hFFFF_FFFF;
   localparam logic [3:0]  IR_RESET   = 4'hF;
   localparam logic [3:0]  IR_CAPTURE = 4'h1;
   localparam logic [15:0] PARAM_MIN [NPARAM] = '{16'h0000, 16'h0010, 16'h0001, 16'h0000};
   localparam logic [15:0] PARAM_MAX [NPARAM] = '{16'h0FFF, 16'h7FFF, 16'h00FF, 16'h0001};

   typedef struct packed {
      logic [CHK_W-1:0]  check;
      logic [DATA_W-1:0] data;
   } bis_fword_t;

   typedef struct packed {
      logic fw_err;
      logic cfg_err;
      logic cfg_blank;
      logic log_err;
      logic ecc_corr;
      logic ecc_uncorr;
      logic addr_invalid;
      logic jtag_on;
   } bis_status_t;

   typedef struct packed {
      logic tck_rise;
      logic tck_fall;
      logic tms;
      logic tdi;
   } bis_tap_in_t;

   typedef enum logic [2:0] {
      ST_STRAP = 3'b100, ST_FW = 3'b000, ST_CFG = 3'b001, ST_LOG = 3'b011,
      ST_RUN = 3'b010, ST_WAIT = 3'b110
   } bis_boot_t;

   typedef enum logic [3:0] {
      T_TLR = 4'b0000, T_RTI = 4'b0001, T_SELDR = 4'b0011, T_CAPDR = 4'b0010,
      T_SHDR = 4'b0110, T_EX1DR = 4'b0111, T_PSDR = 4'b0101, T_EX2DR = 4'b0100,
      T_UPDR = 4'b1100, T_SELIR = 4'b1101, T_CAPIR = 4'b1111, T_SHIR = 4'b1110,
      T_EX1IR = 4'b1010, T_PSIR = 4'b1011, T_EX2IR = 4'b1001, T_UPIR = 4'b1000
   } bis_tap_t;
endpackage : bis_pkg

// ### bis_ecc.sv
// Single-error-correcting Hamming code over a 32-bit flash word
`timescale 1ns/10ps
module bis_ecc (
   input  wire logic [31:0]       enc_data_in,
   output logic [5:0]             enc_check_out,
   input  wire bis_pkg::bis_fword_t dec_word_in,
   output logic [31:0]            dec_data_out,
   output logic                   dec_corr_out,
   output logic                   dec_uncorr_out
);
   import bis_pkg::*;

   // Codeword position of data bit i; powers of two hold check bits
   function automatic logic [5:0] pos_of(input int i);
      int n;
      n = 0;
      pos_of = '0;
      for (int p = 1; p <= 38; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (n == i) pos_of = 6'(p);
            n++;
         end
      end
   endfunction : pos_of

   function automatic logic [5:0] checks(input logic [31:0] d);
      checks = '0;
      for (int i = 0; i < 32; i++) begin
         checks ^= pos_of(i) & {6{d[i]}};
      end
   endfunction : checks

   logic [5:0] syn;

   always_comb begin
      enc_check_out = checks(enc_data_in);
      syn           = checks(dec_word_in.data) ^ dec_word_in.check;
      dec_data_out  = dec_word_in.data;
      for (int i = 0; i < 32; i++) begin
         if (pos_of(i) == syn) dec_data_out[i] = ~dec_word_in.data[i];
      end
      // A syndrome beyond the codeword means more than one bit flipped
      dec_corr_out   = (syn != 6'h00) && (syn <= 6'h26);
      dec_uncorr_out = (syn > 6'h26);
   end
endmodule : bis_ecc

// ### bis_tap.sv
// Test-access port controller with a bypass data path only
`timescale 1ns/10ps
module bis_tap (
   input  wire logic                 clk_in,
   input  wire logic                 reset_in,
   input  wire logic                 enable_in,
   input  wire logic                 tap_en_in,
   input  wire bis_pkg::bis_tap_in_t pins_in,
   output logic                      tdo_out,
   output logic                      tdo_oe_out
);
   import bis_pkg::*;

   bis_tap_t        st_reg;
   logic [IR_W-1:0] ir_reg;
   logic [IR_W-1:0] irsh_reg;
   logic            byp_reg;

   function automatic bis_tap_t nxt(input bis_tap_t s, input logic m);
      unique case (s)
         T_TLR:   nxt = m ? T_TLR   : T_RTI;
         T_RTI:   nxt = m ? T_SELDR : T_RTI;
         T_SELDR: nxt = m ? T_SELIR : T_CAPDR;
         T_CAPDR: nxt = m ? T_EX1DR : T_SHDR;
         T_SHDR:  nxt = m ? T_EX1DR : T_SHDR;
         T_EX1DR: nxt = m ? T_UPDR  : T_PSDR;
         T_PSDR:  nxt = m ? T_EX2DR : T_PSDR;
         T_EX2DR: nxt = m ? T_UPDR  : T_SHDR;
         T_UPDR:  nxt = m ? T_SELDR : T_RTI;
         T_SELIR: nxt = m ? T_TLR   : T_CAPIR;
         T_CAPIR: nxt = m ? T_EX1IR : T_SHIR;
         T_SHIR:  nxt = m ? T_EX1IR : T_SHIR;
         T_EX1IR: nxt = m ? T_UPIR  : T_PSIR;
         T_PSIR:  nxt = m ? T_EX2IR : T_PSIR;
         T_EX2IR: nxt = m ? T_UPIR  : T_SHIR;
         T_UPIR:  nxt = m ? T_SELDR : T_RTI;
      endcase
   endfunction : nxt

   // Every instruction selects the one-bit bypass path; no scan cells exist
   always_ff @(posedge clk_in) begin
      if (reset_in || !tap_en_in) begin
         st_reg   <= T_TLR;
         ir_reg   <= IR_RESET;
         irsh_reg <= IR_RESET;
         byp_reg  <= 1'b0;
      end else if (enable_in && pins_in.tck_rise) begin
         st_reg <= nxt(st_reg, pins_in.tms);
         unique case (st_reg)
            T_TLR:   ir_reg <= IR_RESET;
            T_CAPIR: irsh_reg <= IR_CAPTURE;
            T_SHIR:  irsh_reg <= {pins_in.tdi, irsh_reg[IR_W-1:1]};
            T_UPIR:  ir_reg <= irsh_reg;
            T_CAPDR: byp_reg <= 1'b0;
            T_SHDR:  byp_reg <= pins_in.tdi;
            default: byp_reg <= byp_reg;
         endcase
      end
   end

   // Output changes on the clk_in rising edge after a detected falling test-clock edge, as the port signalling expects
   always_ff @(posedge clk_in) begin
      if (reset_in || !tap_en_in) begin
         tdo_out    <= 1'b0;
         tdo_oe_out <= 1'b0;
      end else if (enable_in && pins_in.tck_fall) begin
         tdo_out    <= (st_reg == T_SHIR) ? irsh_reg[0] : byp_reg;
         tdo_oe_out <= (st_reg == T_SHIR) || (st_reg == T_SHDR);
      end
   end
endmodule : bis_tap

// ### bis_top.sv
// Boot integrity supervisor: power-up checks, port enable, watchdog, flash ECC
`timescale 1ns/10ps
module bis_top #(
   parameter int unsigned WDT_LIMIT = bis_pkg::WDT_CYCLES
) (
   input  wire logic                        clk_in,
   input  wire logic                        reset_in,
   input  wire logic                        enable_in,
   input  wire logic [bis_pkg::STRAP_W-1:0] strap_in,
   input  wire logic                        rom_mode_cmd_in,
   input  wire logic                        wdt_kick_in,
   input  wire logic                        tck_in,
   input  wire logic                        tms_in,
   input  wire logic                        tdi_in,
   input  wire logic                        param_wr_in,
   input  wire logic [1:0]                  param_sel_in,
   input  wire logic [15:0]                 param_val_in,
   input  wire logic                        rd_req_in,
   input  wire logic [bis_pkg::FA_W-1:0]    rd_addr_in,
   input  wire logic                        wr_req_in,
   input  wire logic [bis_pkg::FA_W-1:0]    wr_addr_in,
   input  wire logic [31:0]                 wr_data_in,
   input  wire bis_pkg::bis_fword_t         flash_rd_word_in,
   input  wire logic                        flash_rd_valid_in,
   input  wire logic [bis_pkg::FAST_PWM_OUTPUTS_W-1:0]  pwm_drive_in,
   output logic                             flash_rd_out,
   output logic [bis_pkg::FA_W-1:0]         flash_rd_addr_out,
   output logic                             flash_wr_out,
   output logic [bis_pkg::FA_W-1:0]         flash_wr_addr_out,
   output bis_pkg::bis_fword_t              flash_wr_word_out,
   output logic [31:0]                      rd_data_out,
   output logic                             rd_valid_out,
   output logic                             param_ok_out,
   output logic                             param_rej_out,
   output logic                             fw_run_out,
   output logic                             cmd_only_out,
   output logic                             cfg_default_out,
   output logic                             alert_out_n,
   output bis_pkg::bis_status_t             status_out,
   output logic                             jtag_en_out,
   output logic                             tdo_out,
   output logic                             tdo_oe_out,
   output logic                             gpio_od_out,
   output logic [bis_pkg::FAST_PWM_OUTPUTS_W-1:0]       fast_pwm_outputs,
   output logic                             wdt_reset_out
);
   import bis_pkg::*;

   logic              dev_rst;
   logic              wdt_rst_reg;
   logic [STRAP_W-1:0] strap_s1_reg;
   logic [STRAP_W-1:0] strap_s2_reg;
   logic [2:0]        pin_s1_reg;
   logic [2:0]        pin_s2_reg;
   logic              tck_d_reg;
   bis_tap_in_t       tap_pins;
   bis_boot_t         st_reg;
   logic [FA_W-1:0]   cnt_reg;
   logic [31:0]       sum_reg;
   logic              pend_reg;
   logic              blank_reg, addr_bad_reg, blank_hit_reg, fw_err_reg;
   logic              cfg_err_reg, log_err_reg, ecc_corr_reg, ecc_unc_reg;
   logic [31:0]       wdt_cnt_reg;
   logic [FA_W-1:0]   last_idx;
   logic              sum_ok;
   logic              p_ok;
   logic [5:0]        enc_check;
   logic [31:0]       dec_data;
   logic              dec_corr, dec_unc;

   // A watchdog expiry is handled exactly like a power-up reset
   assign dev_rst = reset_in | wdt_rst_reg;

   bis_ecc u_ecc (
      .enc_data_in    (wr_data_in),
      .enc_check_out  (enc_check),
      .dec_word_in    (flash_rd_word_in),
      .dec_data_out   (dec_data),
      .dec_corr_out   (dec_corr),
      .dec_uncorr_out (dec_unc)
   );

   // Pins pass two flops; left unreset so the straps have settled at release
   always_ff @(posedge clk_in) begin
      if (enable_in) begin
         strap_s1_reg <= strap_in;
         strap_s2_reg <= strap_s1_reg;
         pin_s1_reg   <= {tck_in, tms_in, tdi_in};
         pin_s2_reg   <= pin_s1_reg;
         tck_d_reg    <= pin_s2_reg[2];
      end
   end

   assign tap_pins = {pin_s2_reg[2] & ~tck_d_reg, ~pin_s2_reg[2] & tck_d_reg, pin_s2_reg[1:0]};

   bis_tap u_tap (
      .clk_in     (clk_in),
      .reset_in   (dev_rst),
      .enable_in  (enable_in),
      .tap_en_in  (jtag_en_out),
      .pins_in    (tap_pins),
      .tdo_out    (tdo_out),
      .tdo_oe_out (tdo_oe_out)
   );

   assign last_idx = (st_reg == ST_FW) ? FW_LAST : ((st_reg == ST_CFG) ? CFG_LAST : LOG_LAST);

   // The last word of each region holds the sum of the words before it
   assign sum_ok     = (sum_reg == dec_data);

   // Power-up sequence: straps, firmware, configuration, fault log
   always_ff @(posedge clk_in) begin
      if (dev_rst) begin
         st_reg        <= ST_STRAP;
         cnt_reg       <= '0;
         sum_reg       <= '0;
         pend_reg      <= 1'b0;
         blank_reg     <= 1'b1;
         addr_bad_reg  <= 1'b0;
         blank_hit_reg <= 1'b0;
         fw_err_reg    <= 1'b0;
         cfg_err_reg   <= 1'b0;
         log_err_reg   <= 1'b0;
         flash_rd_out  <= 1'b0;
         flash_rd_addr_out <= FW_BASE;
      end else if (enable_in) begin
         flash_rd_out <= 1'b0;
         unique case (st_reg)
            ST_STRAP: begin
               // Straps are read once here and never again
               addr_bad_reg <= (strap_s2_reg < ADDR_MIN) || (strap_s2_reg > ADDR_MAX);
               st_reg <= ST_FW;
            end
            ST_FW, ST_CFG, ST_LOG: begin
               if (!pend_reg) begin
                  flash_rd_out <= 1'b1;
                  pend_reg     <= 1'b1;
               end else if (flash_rd_valid_in) begin
                  pend_reg <= 1'b0;
                  if (st_reg == ST_CFG) blank_reg <= blank_reg & (dec_data == BLANK_WORD);
                  if (cnt_reg == last_idx) begin
                     cnt_reg <= '0;
                     sum_reg <= '0;
                     unique case (st_reg)
                        ST_FW: begin
                           fw_err_reg <= !sum_ok;
                           flash_rd_addr_out <= CFG_BASE;
                           st_reg <= ST_CFG;
                        end
                        ST_CFG: begin
                           cfg_err_reg   <= !sum_ok;
                           blank_hit_reg <= blank_reg & (dec_data == BLANK_WORD);
                           flash_rd_addr_out <= LOG_BASE;
                           st_reg <= ST_LOG;
                        end
                        default: begin
                           log_err_reg <= !sum_ok;
                           st_reg <= fw_err_reg ? ST_WAIT : ST_RUN;
                        end
                     endcase
                  end else begin
                     sum_reg <= sum_reg + dec_data;
                     cnt_reg <= cnt_reg + 12'h001;
                     flash_rd_addr_out <= flash_rd_addr_out + 12'h001;
                  end
               end
            end
            ST_RUN, ST_WAIT: begin
               if (rd_req_in && !pend_reg) begin
                  flash_rd_out      <= 1'b1;
                  flash_rd_addr_out <= rd_addr_in;
                  pend_reg          <= 1'b1;
               end else if (pend_reg && flash_rd_valid_in) begin
                  pend_reg <= 1'b0;
               end
            end
            default: st_reg <= ST_STRAP;
         endcase
      end
   end

   // Corrected read data and sticky ECC flags
   always_ff @(posedge clk_in) begin
      if (dev_rst) begin
         rd_data_out  <= '0;
         rd_valid_out <= 1'b0;
         ecc_corr_reg <= 1'b0;
         ecc_unc_reg  <= 1'b0;
      end else if (enable_in) begin
         rd_valid_out <= 1'b0;
         if ((st_reg == ST_RUN || st_reg == ST_WAIT) && pend_reg && flash_rd_valid_in) begin
            rd_data_out  <= dec_data;
            rd_valid_out <= 1'b1;
         end
         if (pend_reg && flash_rd_valid_in) begin
            ecc_corr_reg <= ecc_corr_reg | dec_corr;
            ecc_unc_reg  <= ecc_unc_reg | dec_unc;
         end
      end
   end

   // Writes are encoded on the fly; no write is taken before boot ends
   always_ff @(posedge clk_in) begin
      if (dev_rst) begin
         flash_wr_out      <= 1'b0;
         flash_wr_addr_out <= '0;
         flash_wr_word_out <= '0;
      end else if (enable_in) begin
         flash_wr_out <= wr_req_in && (st_reg == ST_RUN || st_reg == ST_WAIT);
         if (wr_req_in) begin
            flash_wr_addr_out <= wr_addr_in;
            flash_wr_word_out <= {enc_check, wr_data_in};
         end
      end
   end

   // Test port enable only ever sets; it needs a reset to clear
   always_ff @(posedge clk_in) begin
      if (dev_rst) begin
         jtag_en_out <= 1'b0;
      end else if (enable_in) begin
         if (rom_mode_cmd_in || blank_hit_reg || addr_bad_reg) begin
            jtag_en_out <= 1'b1;
         end
      end
   end

   // Boot outcome and status
   always_ff @(posedge clk_in) begin
      if (dev_rst) begin
         fw_run_out      <= 1'b0;
         cmd_only_out    <= 1'b0;
         cfg_default_out <= 1'b0;
         alert_out_n     <= 1'b1;
         status_out      <= '0;
      end else if (enable_in) begin
         fw_run_out      <= (st_reg == ST_RUN);
         cmd_only_out    <= (st_reg == ST_WAIT);
         cfg_default_out <= cfg_err_reg;
         alert_out_n     <= ~cfg_err_reg;
         status_out      <= {fw_err_reg, cfg_err_reg, blank_hit_reg, log_err_reg, ecc_corr_reg, ecc_unc_reg,
                             addr_bad_reg, jtag_en_out};
      end
   end

   // Watchdog runs only while firmware executes
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         wdt_cnt_reg <= '0;
         wdt_rst_reg <= 1'b0;
      end else if (enable_in) begin
         wdt_rst_reg <= 1'b0;
         if (st_reg != ST_RUN || wdt_kick_in || wdt_rst_reg) begin
            wdt_cnt_reg <= '0;
         end else if (wdt_cnt_reg == 32'(WDT_LIMIT - 1)) begin
            wdt_cnt_reg <= '0;
            wdt_rst_reg <= 1'b1;
         end else begin
            wdt_cnt_reg <= wdt_cnt_reg + 32'h0000_0001;
         end
      end
   end

   assign wdt_reset_out = wdt_rst_reg;

   // Parameter range screen
   assign p_ok = (param_val_in >= PARAM_MIN[param_sel_in]) && (param_val_in <= PARAM_MAX[param_sel_in]);
   always_ff @(posedge clk_in) begin
      if (dev_rst) begin
         param_ok_out  <= 1'b0;
         param_rej_out <= 1'b0;
      end else if (enable_in) begin
         param_ok_out  <= param_wr_in && p_ok;
         param_rej_out <= param_wr_in && !p_ok;
      end
   end

   // Safe pin states whenever the device sits in reset
   always_ff @(posedge clk_in) begin
      if (dev_rst) begin
         gpio_od_out      <= 1'b1;
         fast_pwm_outputs <= '0;
      end else if (enable_in) begin
         gpio_od_out      <= 1'b0;
         fast_pwm_outputs <= pwm_drive_in;
      end
   end
endmodule : bis_top

// ### bis_properties.sv
// Port-level assertions for the boot integrity supervisor
`timescale 1ns/10ps
module bis_properties (
   input wire logic                 clk_in,
   input wire logic                 reset_in,
   input wire logic                 enable_in,
   input wire logic                 rom_mode_cmd_in,
   input wire logic                 param_wr_in,
   input wire logic [1:0]           param_sel_in,
   input wire logic [15:0]          param_val_in,
   input wire logic                 param_ok_out,
   input wire logic                 param_rej_out,
   input wire logic                 fw_run_out,
   input wire logic                 cmd_only_out,
   input wire logic                 cfg_default_out,
   input wire logic                 alert_out_n,
   input wire bis_pkg::bis_status_t status_out,
   input wire logic                 jtag_en_out,
   input wire logic                 tdo_oe_out,
   input wire logic                 gpio_od_out,
   input wire logic [7:0]           fast_pwm_outputs,
   input wire logic                 wdt_reset_out
);
   import bis_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   chk_reset_state: assert property ($fell(reset_in) |->
      gpio_od_out && !jtag_en_out && fast_pwm_outputs == '0) else $error("reset pin state wrong");
   chk_rom_enable: assert property (rom_mode_cmd_in && enable_in |-> ##[1:3] jtag_en_out)
      else $error("port not enabled by command");
   chk_port_sticky: assert property ($fell(jtag_en_out) |->
      $past(wdt_reset_out) || $past(wdt_reset_out, 2)) else $error("port dropped without reset");
   chk_param_reply: assert property (param_wr_in && enable_in |=> param_ok_out != param_rej_out &&
      param_ok_out == $past(param_val_in >= PARAM_MIN[param_sel_in] && param_val_in <= PARAM_MAX[param_sel_in]))
      else $error("param verdict wrong");
   chk_alert_cause: assert property (!alert_out_n |-> cfg_default_out && status_out.cfg_err)
      else $error("alert without config fault");
   chk_fw_gate: assert property (fw_run_out |-> !cmd_only_out && !status_out.fw_err)
      else $error("firmware runs after bad check");
   chk_wdt_reset: assert property (wdt_reset_out |-> ##[0:1] (gpio_od_out && fast_pwm_outputs == '0))
      else $error("watchdog reset pins wrong");
   chk_port_quiet: assert property (!jtag_en_out |-> !tdo_oe_out)
      else $error("test output driven while off");
endmodule : bis_properties

// ### bis_flash_model.sv
// Flash array model answering reads promptly or slowly
`timescale 1ns/10ps
module bis_flash_model (
   input  wire logic                 clk_in,
   input  wire logic                 rd_in,
   input  wire logic [11:0]          addr_in,
   input  wire logic                 wr_in,
   input  wire logic [11:0]          wr_addr_in,
   input  wire bis_pkg::bis_fword_t  wr_word_in,
   input  wire logic [3:0]           mode_in,
   input  wire logic [5:0]           flip_in,
   input  wire logic                 flip_en_in,
   output bis_pkg::bis_fword_t       word_out,
   output logic                      valid_out
);
   import bis_pkg::*;
   logic [31:0] mem [4096];
   bis_fword_t  wmem [logic [11:0]];
   bis_fword_t  last = '0;
   logic [11:0] ra;
   int          wait_cnt = 0;
   function automatic logic [5:0] chk6(input logic [31:0] d);
      logic [5:0] c;
      int         j;
      c = '0;
      j = 0;
      for (int p = 1; p <= 38; p++) begin
         if ((p & (p - 1)) != 0) begin
            c ^= 6'(p) & {6{d[j]}};
            j++;
         end
      end
      return c;
   endfunction : chk6
   function automatic bis_fword_t fetch(input logic [11:0] a);
      logic [31:0] d;
      d = mem[a];
      if ((mode_in[0] && a == 12'h010) || (mode_in[1] && a == 12'h110) || (mode_in[3] && a == 12'h150)) d++;
      if (mode_in[2] && a >= 12'h100 && a < 12'h140) d = 32'hFFFF_FFFF;
      if (wmem.exists(a)) return wmem[a];
      return {chk6(d), d};
   endfunction : fetch
   initial begin
      logic [31:0] s;
      s = '0;
      for (int a = 0; a < 4096; a++) mem[a] = 32'h1357_0000 + 32'(a);
      // Each region ends in the 32-bit sum of its other words
      for (int a = 0; a < 384; a++) begin
         if (a == 255 || a == 319 || a == 383) begin
            mem[a] = s;
            s = '0;
         end else s += mem[a];
      end
   end
   always @(posedge clk_in) begin
      if (wr_in) wmem[wr_addr_in] = wr_word_in;
      valid_out <= 1'b0;
      word_out <= ~last; // Released bus never repeats the last word
      if (rd_in) begin
         ra = addr_in;
         wait_cnt = addr_in[0] ? 3 : 1;
      end else if (wait_cnt > 0) begin
         wait_cnt--;
         if (wait_cnt == 0) begin
            last = fetch(ra) ^ (flip_en_in ? 38'h1 << flip_in : 38'h0);
            word_out <= last;
            valid_out <= 1'b1;
         end
      end
   end
endmodule : bis_flash_model

// ### bis_top_tb.sv
// Self-checking bench for the boot integrity supervisor
`timescale 1ns/10ps
bind bis_top bis_properties chk_u (.*);
module bis_top_tb;
   import bis_pkg::*;
   logic        clk_in = 1'b0, reset_in = 1'b1, enable_in = 1'b1, rom_mode_cmd_in = 1'b0, wdt_kick_in = 1'b1;
   logic        tck_in = 1'b0, tms_in = 1'b1, tdi_in = 1'b0, param_wr_in = 1'b0, rd_req_in = 1'b0;
   logic        wr_req_in = 1'b0, flash_rd_valid_in, flash_rd_out, flash_wr_out, rd_valid_out, param_ok_out;
   logic        param_rej_out, fw_run_out, cmd_only_out, cfg_default_out, alert_out_n, jtag_en_out, tdo_out;
   logic        tdo_oe_out, gpio_od_out, wdt_reset_out, flip_en = 1'b0;
   logic [6:0]  strap_in = 7'h30;
   logic [1:0]  param_sel_in = 2'h0;
   logic [15:0] param_val_in = 16'h0000;
   logic [11:0] rd_addr_in = 12'h200, wr_addr_in = 12'h200, flash_rd_addr_out, flash_wr_addr_out;
   logic [31:0] wr_data_in = 32'hC0DE_1234, rd_data_out;
   logic [7:0]  pwm_drive_in = 8'h5A, fast_pwm_outputs;
   logic [3:0]  mode = 4'h0;
   logic [5:0]  flip = 6'h00;
   bis_fword_t  flash_rd_word_in, flash_wr_word_out;
   bis_status_t status_out;
   int          fail_count = 0, total_checks = 0, cyc = 0, n;
   bis_top #(.WDT_LIMIT(20)) dut_u (.*);
   bis_flash_model fm_u (.clk_in, .rd_in(flash_rd_out), .addr_in(flash_rd_addr_out), .wr_in(flash_wr_out),
      .wr_addr_in(flash_wr_addr_out), .wr_word_in(flash_wr_word_out), .mode_in(mode), .flip_in(flip),
      .flip_en_in(flip_en), .word_out(flash_rd_word_in), .valid_out(flash_rd_valid_in));
   initial forever #12.5 clk_in = ~clk_in;
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic boot(input logic [6:0] s, input logic [3:0] m);
      @(negedge clk_in);
      strap_in = s;
      mode = m;
      reset_in = 1'b1;
      repeat (16) @(negedge clk_in);
      reset_in = 1'b0;
      for (n = 0; n < 4000 && fw_run_out !== 1'b1 && cmd_only_out !== 1'b1; n++) @(negedge clk_in);
      repeat (4) @(negedge clk_in);
   endtask : boot
   task automatic t_boot_outcomes();
      logic [3:0] m;
      for (int i = 0; i < 5; i++) begin
         m = (i == 0) ? 4'h0 : 4'h1 << (i - 1);
         boot(7'h30, m);
         cmp(fw_run_out, !m[0], "fw run");
         cmp(cmd_only_out, m[0], "cmd only");
         cmp(jtag_en_out, m[2], "blank port");
         cmp(status_out.log_err, m[3], "log flag");
         if (!m[2]) begin
            cmp(cfg_default_out, m[1], "defaults");
            cmp(alert_out_n, !m[1], "alert");
            cmp(status_out.cfg_err, m[1], "cfg flag");
         end
      end
   endtask : t_boot_outcomes
   task automatic t_strap();
      logic [6:0] s [4] = '{7'h07, 7'h08, 7'h77, 7'h78};
      for (int i = 0; i < 4; i++) begin
         boot(s[i], 4'h0);
         strap_in = 7'h00;
         repeat (8) @(negedge clk_in);
         cmp(jtag_en_out, i % 3 == 0, "strap port");
         cmp(status_out.addr_invalid, i % 3 == 0, "strap kept");
      end
   endtask : t_strap
   task automatic t_reset_pins();
      boot(7'h30, 4'h0);
      cmp(gpio_od_out, 1'b0, "od run");
      reset_in = 1'b1;
      repeat (2) @(negedge clk_in);
      cmp(gpio_od_out, 1'b1, "od reset");
      cmp(fast_pwm_outputs, 8'h00, "pwm reset");
      cmp(jtag_en_out, 1'b0, "port off");
   endtask : t_reset_pins
   task automatic t_param();
      logic [17:0] tab [8] = '{{2'h0, 16'h0FFF}, {2'h0, 16'h1000}, {2'h1, 16'h0010}, {2'h1, 16'h000F},
         {2'h2, 16'h00FF}, {2'h2, 16'h0000}, {2'h3, 16'h0001}, {2'h3, 16'h0002}};
      foreach (tab[i]) begin
         {param_sel_in, param_val_in} = tab[i];
         param_wr_in = 1'b1;
         @(negedge clk_in);
         param_wr_in = 1'b0;
         cmp(param_ok_out, i % 2 == 0, "param ok");
         cmp(param_rej_out, i % 2 == 1, "param rej");
         @(negedge clk_in);
      end
   endtask : t_param
   task automatic tck_step(input logic ms, input logic di);
      {tms_in, tdi_in} = {ms, di};
      repeat (4) @(negedge clk_in);
      tck_in = 1'b1;
      repeat (4) @(negedge clk_in);
      tck_in = 1'b0;
      repeat (5) @(negedge clk_in);
   endtask : tck_step
   task automatic t_rom_tap();
      logic [3:0] pat = 4'hB;
      cmp(jtag_en_out, 1'b0, "port idle");
      rom_mode_cmd_in = 1'b1;
      @(negedge clk_in);
      rom_mode_cmd_in = 1'b0;
      repeat (3) @(negedge clk_in);
      cmp(jtag_en_out, 1'b1, "rom port");
      for (int i = 0; i < 4; i++) tck_step(i == 1, 1'b0);
      for (int i = 0; i < 4; i++) begin
         tck_step(1'b0, pat[i]);
         cmp(tdo_out, pat[i], "bypass bit");
         cmp(tdo_oe_out, 1'b1, "tdo drive");
      end
   endtask : t_rom_tap
   task automatic t_ecc();
      wr_req_in = 1'b1;
      @(negedge clk_in);
      wr_req_in = 1'b0;
      cmp(flash_wr_out, 1'b1, "wr strobe");
      cmp(flash_wr_word_out.check, fm_u.chk6(32'hC0DE_1234), "check bits");
      flip_en = 1'b1;
      for (int b = 0; b < 38; b += 9) begin
         flip = 6'(b);
         rd_req_in = 1'b1;
         @(negedge clk_in);
         rd_req_in = 1'b0;
         for (n = 0; n < 20 && rd_valid_out !== 1'b1; n++) @(negedge clk_in);
         cmp(rd_data_out, 32'hC0DE_1234, "ecc read");
      end
      flip_en = 1'b0;
   endtask : t_ecc
   task automatic t_wdt();
      wdt_kick_in = 1'b0;
      for (n = 0; n < 60 && wdt_reset_out !== 1'b1; n++) @(negedge clk_in);
      cmp(wdt_reset_out, 1'b1, "wdt fired");
      wdt_kick_in = 1'b1;
      @(negedge clk_in);
      cmp(gpio_od_out, 1'b1, "wdt od");
      cmp(fast_pwm_outputs, 8'h00, "wdt pwm");
      cmp(jtag_en_out, 1'b0, "wdt port");
      for (n = 0; n < 4000 && fw_run_out !== 1'b1; n++) @(negedge clk_in);
      cmp(fw_run_out, 1'b1, "reboot");
   endtask : t_wdt
   initial begin
      t_boot_outcomes();
      t_strap();
      t_reset_pins();
      boot(7'h30, 4'h0);
      t_param();
      t_rom_tap();
      t_ecc();
      t_wdt();
      print_verdict();
   end
endmodule : bis_top_tb
